/* ism_map.svh */
`ifndef ISM_MAP_SVH
`define ISM_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define ISM_CRIT_LIMIT_OFS 8'h51
`define ISM_ADP_DETECT_OFS 8'h69
`define ISM_SRC_STATUS_OFS 8'h6F

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define ISM_CRIT_LIMIT_RST 8'h05
`define ISM_ADP_DETECT_RST 8'h0F

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define ISM_COMP_EN_BIT 6
`define ISM_DG_SEL_HI 5
`define ISM_DG_SEL_LO 4
`define ISM_THR_SEL_HI 3
`define ISM_THR_SEL_LO 0
`define ISM_DB_SEL_HI 3
`define ISM_DB_SEL_LO 2
`define ISM_EDGE_SEL_HI 1
`define ISM_EDGE_SEL_LO 0
`define ISM_ADP_STAT_BIT 4

// ----------------------------------------------------------------------------
// Timing: clock rate, times in their own units, derived cycle counts
// ----------------------------------------------------------------------------
`define ISM_CLK_MHZ 10
`define ISM_DG_10US_NS 10000
`define ISM_RTC_PERIOD_NS 30000
`define ISM_DB_81US_NS 81000
`define ISM_DB_10MS_US 10000
`define ISM_DB_20MS_US 20000
`define ISM_DB_30MS_US 30000
// Least times round up to whole cycles
`define ISM_NS_TO_CYC(ns) (((ns) * `ISM_CLK_MHZ + 999) / 1000)
`define ISM_US_TO_CYC(us) ((us) * `ISM_CLK_MHZ)
`define ISM_DG_10US_CYC `ISM_NS_TO_CYC(`ISM_DG_10US_NS)
`define ISM_DG_1RTC_CYC `ISM_NS_TO_CYC(`ISM_RTC_PERIOD_NS)
`define ISM_DG_2RTC_CYC `ISM_NS_TO_CYC(2 * `ISM_RTC_PERIOD_NS)
`define ISM_DB_81US_CYC `ISM_NS_TO_CYC(`ISM_DB_81US_NS)

`endif

/* ism_pkg.sv */
package ism_pkg;

    // Register access request from the serial-interface front end
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ism_reg_req_t;

    // Register read answer
    typedef struct packed {
        logic [7:0] rdata;
        logic valid;
    } ism_reg_rsp_t;

    // Settings handed to the analog comparator
    typedef struct packed {
        logic comp_en;
        logic [3:0] thr_sel;
    } ism_comp_cfg_t;

endpackage

/* ism_monitor.sv */
// Functional notes
// - Critical supply comparator runs only while limit register bit 6 is set.
// - Supply result deglitch: code 0 none, 1 10us, 2 30us, 3 60us.
// - Threshold field bits 3-0 picks 1.2V..1.08V; code 0 disables the limit.
// - Adapter debounce time by bits 3-2: 81us, 10ms, 20ms, 30ms.
// - Adapter edge mode: 1 rising, 2 falling, 3 both; 0 reserved.
// - Critical limit register resets to 0x05.
// - Adapter detection register resets to 0x0F.
// - Debounced adapter state reads back at status register bit 4.
`timescale 1ns/1ns
`default_nettype none
`include "ism_map.svh"

module ism_monitor
    import ism_pkg::*;
#(
    parameter int unsigned DB_10MS_CYC = `ISM_US_TO_CYC(`ISM_DB_10MS_US),
    parameter int unsigned DB_20MS_CYC = `ISM_US_TO_CYC(`ISM_DB_20MS_US),
    parameter int unsigned DB_30MS_CYC = `ISM_US_TO_CYC(`ISM_DB_30MS_US)
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic srst_i,
    // Register access
    input wire ism_reg_req_t reg_req_i,
    output ism_reg_rsp_t reg_rsp_o,
    // Analog comparator interface
    input wire logic supply_below_i,
    output ism_comp_cfg_t comp_cfg_o,
    output logic supply_low_o,
    // Adapter sense
    input wire logic adapter_present_input_i,
    output logic adapter_present_status_o,
    output logic adapter_event_o
);

    // ------------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------------
    logic [7:0] crit_supply_limit_ctrl_reg;
    logic [7:0] adapter_detect_ctrl_reg;
    logic critical_comparator_enable;
    logic [1:0] supply_monitor_deglitch_sel;
    logic [3:0] critical_falling_threshold_sel;
    logic [1:0] adapter_debounce_sel;
    logic [1:0] adapter_edge_mode_sel;
    logic supply_gate;

    // Reserved bits are plain storage, so full bytes are written
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            crit_supply_limit_ctrl_reg <= `ISM_CRIT_LIMIT_RST;
        end else if (reg_req_i.wr && reg_req_i.addr == `ISM_CRIT_LIMIT_OFS) begin
            crit_supply_limit_ctrl_reg <= reg_req_i.wdata;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            adapter_detect_ctrl_reg <= `ISM_ADP_DETECT_RST;
        end else if (reg_req_i.wr && reg_req_i.addr == `ISM_ADP_DETECT_OFS) begin
            adapter_detect_ctrl_reg <= reg_req_i.wdata;
        end
    end

    // Field extraction
    assign critical_comparator_enable = crit_supply_limit_ctrl_reg[`ISM_COMP_EN_BIT];
    assign supply_monitor_deglitch_sel = crit_supply_limit_ctrl_reg[`ISM_DG_SEL_HI:`ISM_DG_SEL_LO];
    assign critical_falling_threshold_sel = crit_supply_limit_ctrl_reg[`ISM_THR_SEL_HI:`ISM_THR_SEL_LO];
    assign adapter_debounce_sel = adapter_detect_ctrl_reg[`ISM_DB_SEL_HI:`ISM_DB_SEL_LO];
    assign adapter_edge_mode_sel = adapter_detect_ctrl_reg[`ISM_EDGE_SEL_HI:`ISM_EDGE_SEL_LO];
    // Codes 8h-Fh get no special decode; they just count as a nonzero limit
    assign supply_gate = critical_comparator_enable && (critical_falling_threshold_sel != 4'h0);

    // Comparator settings go out registered so the analog side sees clean levels
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            comp_cfg_o <= '0;
        end else begin
            comp_cfg_o.comp_en <= supply_gate;
            comp_cfg_o.thr_sel <= critical_falling_threshold_sel;
        end
    end

    // ------------------------------------------------------------------------
    // Filter intervals: channel 0 supply deglitch, channel 1 adapter debounce
    // ------------------------------------------------------------------------
    logic [18:0] flt_lim [2];
    logic flt_raw [2];
    logic flt_lvl [2];
    logic [18:0] flt_cnt [2];

    always_comb begin
        case (supply_monitor_deglitch_sel)
            2'd0: flt_lim[0] = 19'h0_0000;
            2'd1: flt_lim[0] = 19'(`ISM_DG_10US_CYC);
            2'd2: flt_lim[0] = 19'(`ISM_DG_1RTC_CYC);
            default: flt_lim[0] = 19'(`ISM_DG_2RTC_CYC);
        endcase
        case (adapter_debounce_sel)
            2'd0: flt_lim[1] = 19'(`ISM_DB_81US_CYC);
            2'd1: flt_lim[1] = 19'(DB_10MS_CYC);
            2'd2: flt_lim[1] = 19'(DB_20MS_CYC);
            default: flt_lim[1] = 19'(DB_30MS_CYC);
        endcase
    end

    // A disabled comparator reads as "not low", so the filter drains to 0
    assign flt_raw[0] = supply_gate && supply_below_i;
    assign flt_raw[1] = adapter_present_input_i;

    // ------------------------------------------------------------------------
    // Stability filters: a level is accepted after lim cycles of disagreement
    // ------------------------------------------------------------------------
    for (genvar g = 0; g < 2; g++) begin : g_flt
        always_ff @(posedge ref_clk_i) begin
            if (srst_i) begin
                flt_lvl[g] <= 1'b0;
                flt_cnt[g] <= 19'h0_0000;
            end else if (flt_raw[g] == flt_lvl[g]) begin
                flt_cnt[g] <= 19'h0_0000; // Bounce back restarts the interval
            end else if (flt_cnt[g] + 19'h0_0001 >= flt_lim[g]) begin
                flt_lvl[g] <= flt_raw[g];
                flt_cnt[g] <= 19'h0_0000;
            end else begin
                flt_cnt[g] <= flt_cnt[g] + 19'h0_0001;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Outputs from the filters
    // ------------------------------------------------------------------------
    logic adp_lvl_d_reg;
    logic adp_rise;
    logic adp_fall;

    assign adp_rise = flt_lvl[1] && !adp_lvl_d_reg;
    assign adp_fall = !flt_lvl[1] && adp_lvl_d_reg;

    // Output gate keeps supply_low_o quiet at once when monitoring is switched off
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            supply_low_o <= 1'b0;
        end else begin
            supply_low_o <= flt_lvl[0] && supply_gate;
        end
    end

    // Reserved mode 0 matches neither edge, so it simply reports nothing
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            adp_lvl_d_reg <= 1'b0;
            adapter_event_o <= 1'b0;
            adapter_present_status_o <= 1'b0;
        end else begin
            adp_lvl_d_reg <= flt_lvl[1];
            adapter_event_o <= (adp_rise && adapter_edge_mode_sel[0])
                || (adp_fall && adapter_edge_mode_sel[1]);
            adapter_present_status_o <= flt_lvl[1];
        end
    end

    // ------------------------------------------------------------------------
    // Register read path: one cycle latency, unmapped reads return zero
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            reg_rsp_o <= '0;
        end else begin
            reg_rsp_o.valid <= reg_req_i.rd;
            if (!reg_req_i.rd) begin
                reg_rsp_o.rdata <= 8'h00;
            end else begin
                case (reg_req_i.addr)
                    `ISM_CRIT_LIMIT_OFS: reg_rsp_o.rdata <= crit_supply_limit_ctrl_reg;
                    `ISM_ADP_DETECT_OFS: reg_rsp_o.rdata <= adapter_detect_ctrl_reg;
                    `ISM_SRC_STATUS_OFS: reg_rsp_o.rdata <= 8'(flt_lvl[1]) << `ISM_ADP_STAT_BIT;
                    default: reg_rsp_o.rdata <= 8'h00;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    sequence s_adp_rise_seen;
        adp_rise && adapter_edge_mode_sel[0];
    endsequence

    sequence s_adp_fall_seen;
        adp_fall && adapter_edge_mode_sel[1];
    endsequence

    a_reset_crit_value: assert property (@(posedge ref_clk_i) srst_i |=> crit_supply_limit_ctrl_reg == 8'h05)
        else $error("critical limit register not 0x05 after reset");

    a_reset_adp_value: assert property (@(posedge ref_clk_i) srst_i |=> adapter_detect_ctrl_reg == 8'h0F)
        else $error("adapter register not 0x0F after reset");

    a_comp_disable_quiet: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        !critical_comparator_enable |=> !supply_low_o && !comp_cfg_o.comp_en)
        else $error("supply low reported with comparator disabled");

    a_no_limit_quiet: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        critical_falling_threshold_sel == 4'h0 |=> !supply_low_o)
        else $error("supply low reported with threshold code 0");

    a_deglitch_ten_us: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        supply_monitor_deglitch_sel == 2'd1 && flt_raw[0] != flt_lvl[0] && flt_cnt[0] < 19'd99
        |=> flt_lvl[0] == $past(flt_lvl[0]))
        else $error("supply level accepted before 10 us");

    a_filter_restart: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        flt_raw[1] == flt_lvl[1] |=> flt_cnt[1] == 19'h0_0000 && flt_lvl[1] == $past(flt_lvl[1]))
        else $error("adapter filter did not restart on agreement");

    a_debounce_81us: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        $changed(flt_lvl[1]) |-> $past(flt_cnt[1]) == 19'd809 || $past(adapter_debounce_sel) != 2'd0)
        else $error("adapter level accepted off the 81 us count");

    a_edge_event: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (s_adp_rise_seen or s_adp_fall_seen) |=> adapter_event_o)
        else $error("selected adapter edge not reported");

    a_edge_masked: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        adapter_event_o |-> $past(adp_rise && adapter_edge_mode_sel[0] || adp_fall && adapter_edge_mode_sel[1]))
        else $error("adapter event without a selected edge");

    a_status_read: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        reg_req_i.rd && reg_req_i.addr == 8'h6F
        |=> reg_rsp_o.valid && reg_rsp_o.rdata == {3'b000, $past(flt_lvl[1]), 4'h0})
        else $error("status read does not show adapter state at bit 4");

endmodule

`default_nettype wire

/* ism_src_model.sv */
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------------------
// Source side: supply comparator output and adapter sense line
// ----------------------------------------------------------------------------
module ism_src_model (
    // Commands from the bench
    input wire logic below_cmd_i,
    input wire logic adp_cmd_i,
    // Lines into the block
    output logic supply_below_o,
    output logic adapter_present_o
);
    // Both lines are always-driven levels, so there is no released state to mimic
    assign supply_below_o = below_cmd_i;
    assign adapter_present_o = adp_cmd_i;
endmodule

`default_nettype wire

/* ism_monitor_tb.sv */
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------------------
// Bench for the supply and adapter monitor
// ----------------------------------------------------------------------------
module ism_monitor_tb import ism_pkg::*;;
    localparam int D = 10;
    logic ref_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic below = 1'b0;
    logic adp = 1'b0;
    ism_reg_req_t req = '0;
    ism_reg_rsp_t rsp;
    ism_comp_cfg_t cfg;
    logic sb;
    logic ap;
    logic slow;
    logic stat;
    logic evt;
    int err_total = 0;
    int check_count = 0;
    logic [31:0] lf = 32'h1be1_99f1;
    logic [7:0] rq[$];
    logic eq[$];

    // Short debounce counts keep the run brief
    ism_src_model i_ism_src_model (.below_cmd_i(below), .adp_cmd_i(adp), .supply_below_o(sb),
        .adapter_present_o(ap));
    ism_monitor #(.DB_10MS_CYC(20), .DB_20MS_CYC(40), .DB_30MS_CYC(60)) i_ism_monitor (.ref_clk_i(ref_clk_i),
        .srst_i(srst_i), .reg_req_i(req), .reg_rsp_o(rsp), .supply_below_i(sb), .comp_cfg_o(cfg),
        .supply_low_o(slow), .adapter_present_input_i(ap), .adapter_present_status_o(stat),
        .adapter_event_o(evt));

    initial begin
        forever #50 ref_clk_i = ~ref_clk_i;
    end

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input string nm, input logic [11:0] seen, input logic [11:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Inputs always move the same small delay after the rising edge
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
        #D;
    endtask

    // A gap cycle after each strobe keeps every strobe a clean one-cycle pulse
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        cyc(1);
        req = '0;
        cyc(1);
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
        rq.push_back(e);
        req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        cyc(1);
        req = '0;
        cyc(1);
    endtask

    // Edges until the watched level reaches v, bounded so a dead filter cannot hang
    task automatic settle(input logic sel, input logic v, input int n, output int k);
        k = 0;
        while (((sel ? stat : slow) !== v) && k < n + 3) begin
            cyc(1);
            k++;
        end
    endtask

    // Sampled on the falling edge, where registered outputs have settled
    always @(negedge ref_clk_i) begin
        if (rsp.valid === 1'b1) begin
            if (rq.size() == 0) check("stray read", 12'd1, 12'd0);
            else check("read data", 12'(rsp.rdata), 12'(rq.pop_front()));
        end
        if (evt === 1'b1) begin
            if (eq.size() == 0) check("stray event", 12'd1, 12'd0);
            else check("event level", 12'(stat), 12'(eq.pop_front()));
        end
    end

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        int k;
        int n;
        logic [3:0] th;
        logic [7:0] d;
        cyc(6);
        srst_i = 1'b0;
        reg_rd(8'h51, 8'h05);
        reg_rd(8'h69, 8'h0f);
        reg_wr(8'h6f, 8'hff);
        reg_wr(8'h33, 8'hff);
        reg_rd(8'h6f, 8'h00);
        reg_rd(8'h33, 8'h00);
        check("cfg reset", 12'(cfg), 12'h005);
        for (int i = 0; i < 4; i++) begin
            lf = lfsr(lf);
            th = 4'(1 + lf % 7); // Stay inside the defined threshold codes
            n = (i == 0) ? 1 : (i == 1) ? 100 : 300 * (i - 1);
            reg_wr(8'h51, {2'b01, 2'(i), th});
            reg_rd(8'h51, {2'b01, 2'(i), th});
            check("cfg on", 12'(cfg), 12'({1'b1, th}));
            if (n > 1) begin
                below = 1'b1;
                cyc(n - 1);
                below = 1'b0;
                cyc(4);
                check("glitch", 12'(slow), 12'd0);
            end
            below = 1'b1;
            settle(1'b0, 1'b1, n, k);
            check("low rise", 12'(k), 12'(n + 1));
            below = 1'b0;
            settle(1'b0, 1'b0, n, k);
            check("low fall", 12'(k), 12'(n + 1));
        end
        // Turning off either the enable or the threshold must drop the alarm
        for (int j = 0; j < 2; j++) begin
            reg_wr(8'h51, {4'h4, th});
            below = 1'b1;
            settle(1'b0, 1'b1, 1, k);
            check("gated rise", 12'(k), 12'd2);
            reg_wr(8'h51, j ? {4'h0, th} : 8'h40);
            cyc(1);
            check("gated cfg", 12'(cfg), j ? 12'(th) : 12'd0);
            check("gated low", 12'(slow), 12'd0);
            below = 1'b0;
        end
        for (int m = 0; m < 4; m++) begin
            n = (m == 0) ? 810 : 20 * m;
            lf = lfsr(lf);
            d = {lf[7:4], 2'(m), 2'(m)};
            reg_wr(8'h69, d);
            reg_rd(8'h69, d);
            if (m[0]) eq.push_back(1'b1);
            adp = 1'b1;
            settle(1'b1, 1'b1, n, k);
            check("debounce rise", 12'(k), 12'(n + 1));
            reg_rd(8'h6f, 8'h10);
            if (m[1]) eq.push_back(1'b0);
            adp = 1'b0;
            settle(1'b1, 1'b0, n, k);
            check("debounce fall", 12'(k), 12'(n + 1));
            reg_rd(8'h6f, 8'h00);
        end
        // A second reset mid-run must bring both registers back to their defaults
        srst_i = 1'b1;
        cyc(2);
        srst_i = 1'b0;
        reg_rd(8'h51, 8'h05);
        reg_rd(8'h69, 8'h0f);
        check("cfg second reset", 12'(cfg), 12'h005);
        cyc(4);
        if (rq.size() != 0 || eq.size() != 0) check("pending", 12'd1, 12'd0);
        results();
    end

    // The whole sequence needs about 5000 cycles; this allows six times that
    initial begin
        #(30000 * 100);
        check("watchdog", 12'd1, 12'd0);
        results();
    end
endmodule

`default_nettype wire
